// File: design/dspdp_pkg.sv
// constants and enumerations for the dsp arithmetic datapath
// assumes a single 100 MHz system clock and an external sequencer
package dspdp_pkg;

	// register file shape
	localparam int DSPDP_NREGS = 8;
	localparam int DSPDP_W = 40;
	localparam int DSPDP_SEL_W = 3;

	// part field positions
	localparam int DSPDP_LOW_LSB = 0;
	localparam int DSPDP_HIGH_LSB = 16;
	localparam int DSPDP_EXT_LSB = 32;

	// reset value of every register
	localparam logic [39:0] DSPDP_REG_RST = 40'h00_0000_0000;

	// pre-shift amounts of the accumulate path
	localparam int DSPDP_PSH_SMALL = 1;
	localparam int DSPDP_PSH_LARGE = 16;

	// operation latency in system clocks
	localparam int DSPDP_OP_CYCLES = 1;

	// operation codes
	typedef enum logic [3:0] {
		DSPDP_OP_NOP = 4'h0,
		DSPDP_OP_MAC_ADD = 4'h1,
		DSPDP_OP_MAC_SUB = 4'h2,
		DSPDP_OP_ADD = 4'h3,
		DSPDP_OP_SUB = 4'h4,
		DSPDP_OP_AND = 4'h5,
		DSPDP_OP_OR = 4'h6,
		DSPDP_OP_XOR = 4'h7,
		DSPDP_OP_NEG = 4'h8,
		DSPDP_OP_NOT = 4'h9,
		DSPDP_OP_PASS = 4'hA,
		DSPDP_OP_SHL = 4'hB,
		DSPDP_OP_SRA = 4'hC,
		DSPDP_OP_SRL = 4'hD
	} dspdp_op_t;

	// accumulate pre-shift selection
	typedef enum logic [1:0] {
		DSPDP_PSH_NONE = 2'h0,
		DSPDP_PSH_BY1 = 2'h1,
		DSPDP_PSH_BY16 = 2'h3
	} dspdp_psh_t;

	// part selection for loads and stores
	typedef enum logic [1:0] {
		DSPDP_PART_LOW = 2'h0,
		DSPDP_PART_HIGH = 2'h1,
		DSPDP_PART_EXT = 2'h2,
		DSPDP_PART_WHOLE = 2'h3
	} dspdp_part_t;

endpackage

// File: design/dspdp_shifter.sv
// full width barrel shifter for the dsp datapath
// assumes the caller registers the result; purely combinational
module dspdp_shifter
	import dspdp_pkg::*;
#(
	parameter int W = 40
) (
	// operand and control
	input wire logic [W-1:0] data_i,
	input wire logic [5:0] amount_i,
	input wire logic left_i,
	input wire logic arith_i,
	// result
	output logic [W-1:0] data_o
);

	////////////////////////////////////////////////////////////////////////
	// shift, amounts at or beyond the width saturate to a full fill
	always_comb begin
		logic signed [W-1:0] sop;
		sop = $signed(data_i);
		if (amount_i >= 6'(W)) begin
			// everything shifted out
			if (left_i)
				data_o = '0;
			else
				data_o = arith_i ? {W{data_i[W-1]}} : '0;
		end else if (left_i) begin
			data_o = data_i << amount_i; // zero fill, top bits lost
		end else if (arith_i) begin
			data_o = W'(sop >>> amount_i); // sign copies from the top
		end else begin
			data_o = data_i >> amount_i; // zeros from the msb
		end
	end

endmodule

// File: design/dspdp_top.sv
// arithmetic datapath of a 16-bit fixed point dsp: register file, mac, alu, shifter
// assumes the sequencer issues one operation per clock and memory loads/stores
module dspdp_top
	import dspdp_pkg::*;
#(
	parameter int NREGS = DSPDP_NREGS
) (
	// clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RESETN_I,
	// operation issue from the sequencer
	input wire logic OP_VALID_I,
	input wire logic [3:0] OP_CODE_I,
	input wire logic [2:0] OP_DST_I,
	input wire logic [2:0] OP_SRCA_I,
	input wire logic [2:0] OP_SRCB_I,
	input wire logic OP_MUL_A_HIGH_I,
	input wire logic OP_MUL_B_HIGH_I,
	input wire logic [1:0] OP_PRESHIFT_I,
	input wire logic [5:0] OP_SHAMT_I,
	// memory load into a register part
	input wire logic LOAD_VALID_I,
	input wire logic [2:0] LOAD_REG_I,
	input wire logic [1:0] LOAD_PART_I,
	input wire logic [39:0] LOAD_DATA_I,
	// memory store out of a register part
	input wire logic STORE_REQ_I,
	input wire logic [2:0] STORE_REG_I,
	input wire logic [1:0] STORE_PART_I,
	output logic STORE_VALID_O,
	output logic [39:0] STORE_DATA_O,
	// operation completion
	output logic DONE_O,
	output logic [39:0] RESULT_O
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// read one part of a register, zero extended; whole gives all 40 bits
	function automatic logic [39:0] part_read(input logic [39:0] r, input logic [1:0] p);
		case (p)
			DSPDP_PART_LOW: part_read = {24'h00_0000, r[DSPDP_HIGH_LSB-1:DSPDP_LOW_LSB]};
			DSPDP_PART_HIGH: part_read = {24'h00_0000, r[DSPDP_EXT_LSB-1:DSPDP_HIGH_LSB]};
			DSPDP_PART_EXT: part_read = {32'h0000_0000, r[39:DSPDP_EXT_LSB]};
			default: part_read = r;
		endcase
	endfunction

	// write one part of a register, other parts untouched
	function automatic logic [39:0] part_write(input logic [39:0] r, input logic [1:0] p,
		input logic [39:0] d);
		logic [39:0] n;
		n = r;
		case (p)
			DSPDP_PART_LOW: n[15:0] = d[15:0];
			DSPDP_PART_HIGH: n[31:16] = d[15:0];
			DSPDP_PART_EXT: n[39:32] = d[7:0];
			default: n = d;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic [39:0] gp_reg [NREGS]; // general purpose registers
	logic [39:0] gp_next [NREGS]; // their next values
	logic done_reg; // completion pulse
	logic done_next;
	logic [39:0] result_reg; // last operation result
	logic [39:0] result_next;
	logic store_valid_reg; // store data valid pulse
	logic store_valid_next;
	logic [39:0] store_data_reg; // part delivered to memory
	logic [39:0] store_data_next;

	logic [39:0] opa; // operand a
	logic [39:0] opb; // operand b
	logic [39:0] acc_in; // pre-shifted accumulate operand
	logic signed [31:0] product; // 16x16 product
	logic [39:0] mac_out; // mac result
	logic [39:0] alu_out; // alu result
	logic [39:0] sh_out; // barrel shifter result
	logic [39:0] op_out; // selected result
	logic op_writes; // op targets the register file

	assign opa = gp_reg[OP_SRCA_I];
	assign opb = gp_reg[OP_SRCB_I];

	////////////////////////////////////////////////////////////////////////
	// barrel shifter, direction and fill from the opcode
	dspdp_shifter #(
		.W(DSPDP_W)
	) u_full_width_shifter (
		.data_i(opa),
		.amount_i(OP_SHAMT_I),
		.left_i(OP_CODE_I == DSPDP_OP_SHL),
		.arith_i(OP_CODE_I == DSPDP_OP_SRA),
		.data_o(sh_out)
	);

	////////////////////////////////////////////////////////////////////////
	// mac: multiplier operands are the low or high parts of the sources
	always_comb begin
		logic signed [15:0] ma;
		logic signed [15:0] mb;
		logic signed [39:0] sacc;
		ma = OP_MUL_A_HIGH_I ? opa[31:16] : opa[15:0];
		mb = OP_MUL_B_HIGH_I ? opb[31:16] : opb[15:0];
		product = ma * mb;
		sacc = $signed(gp_reg[OP_DST_I]);
		// pre-shifter keeps the sign, so scaled accumulations stay correct
		case (OP_PRESHIFT_I)
			DSPDP_PSH_BY1: acc_in = 40'(sacc >>> DSPDP_PSH_SMALL);
			DSPDP_PSH_BY16: acc_in = 40'(sacc >>> DSPDP_PSH_LARGE);
			default: acc_in = gp_reg[OP_DST_I];
		endcase
		// wraps modulo 2^40; no saturation here
		if (OP_CODE_I == DSPDP_OP_MAC_SUB)
			mac_out = acc_in - 40'(product);
		else
			mac_out = acc_in + 40'(product);
	end

	////////////////////////////////////////////////////////////////////////
	// alu, one or two operands
	always_comb begin
		case (OP_CODE_I)
			DSPDP_OP_ADD: alu_out = opa + opb;
			DSPDP_OP_SUB: alu_out = opa - opb;
			DSPDP_OP_AND: alu_out = opa & opb;
			DSPDP_OP_OR: alu_out = opa | opb;
			DSPDP_OP_XOR: alu_out = opa ^ opb;
			DSPDP_OP_NEG: alu_out = 40'h00_0000_0000 - opa; // single operand
			DSPDP_OP_NOT: alu_out = ~opa;
			default: alu_out = opa; // pass
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// result select
	always_comb begin
		case (OP_CODE_I)
			DSPDP_OP_MAC_ADD, DSPDP_OP_MAC_SUB: op_out = mac_out;
			DSPDP_OP_SHL, DSPDP_OP_SRA, DSPDP_OP_SRL: op_out = sh_out;
			default: op_out = alu_out;
		endcase
		op_writes = OP_VALID_I && (OP_CODE_I != DSPDP_OP_NOP);
	end

	////////////////////////////////////////////////////////////////////////
	// next state: results and loads; a load to the same register wins
	// because memory data is the later program order in the pipeline
	always_comb begin
		for (int i = 0; i < NREGS; i++) begin
			gp_next[i] = gp_reg[i];
		end
		if (op_writes)
			gp_next[OP_DST_I] = op_out; // one clock per operation
		if (LOAD_VALID_I)
			gp_next[LOAD_REG_I] = part_write(gp_next[LOAD_REG_I], LOAD_PART_I,
				LOAD_DATA_I);
		done_next = op_writes;
		result_next = op_writes ? op_out : result_reg;
		store_valid_next = STORE_REQ_I;
		store_data_next = STORE_REQ_I ? part_read(gp_reg[STORE_REG_I], STORE_PART_I) :
			store_data_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			for (int i = 0; i < NREGS; i++) begin
				gp_reg[i] <= DSPDP_REG_RST;
			end
			done_reg <= 1'b0;
			result_reg <= DSPDP_REG_RST;
			store_valid_reg <= 1'b0;
			store_data_reg <= DSPDP_REG_RST;
		end else begin
			for (int i = 0; i < NREGS; i++) begin
				gp_reg[i] <= gp_next[i];
			end
			done_reg <= done_next;
			result_reg <= result_next;
			store_valid_reg <= store_valid_next;
			store_data_reg <= store_data_next;
		end
	end

	assign DONE_O = done_reg;
	assign RESULT_O = result_reg;
	assign STORE_VALID_O = store_valid_reg;
	assign STORE_DATA_O = store_data_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_issue_add;
		OP_VALID_I && OP_CODE_I == DSPDP_OP_ADD && !LOAD_VALID_I;
	endsequence

	property p_add;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		s_issue_add |=> RESULT_O == 40'($past(opa) + $past(opb));
	endproperty
	a_add: assert property (p_add) else $error("alu add wrong");

	property p_done;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(OP_VALID_I && OP_CODE_I != DSPDP_OP_NOP) |=> DONE_O;
	endproperty
	a_done: assert property (p_done) else $error("op not done in one cycle");

	property p_wb;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(op_writes && !LOAD_VALID_I) |=> gp_reg[$past(OP_DST_I)] == RESULT_O;
	endproperty
	a_wb: assert property (p_wb) else $error("result not written back");

	property p_sra;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(OP_VALID_I && OP_CODE_I == DSPDP_OP_SRA && OP_SHAMT_I != 6'h00 && opa[39])
		|=> RESULT_O[39];
	endproperty
	a_sra: assert property (p_sra) else $error("sign not copied");

	property p_srl;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(OP_VALID_I && OP_CODE_I == DSPDP_OP_SRL && OP_SHAMT_I != 6'h00) |=> !RESULT_O[39];
	endproperty
	a_srl: assert property (p_srl) else $error("logical shift msb not zero");

	property p_shl;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(OP_VALID_I && OP_CODE_I == DSPDP_OP_SHL && OP_SHAMT_I != 6'h00) |=> !RESULT_O[0];
	endproperty
	a_shl: assert property (p_shl) else $error("left shift lsb not zero");

	property p_store_low;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(STORE_REQ_I && STORE_PART_I == DSPDP_PART_LOW) |=> STORE_VALID_O &&
			STORE_DATA_O[39:16] == 24'h00_0000;
	endproperty
	a_store_low: assert property (p_store_low) else $error("low store wrong");

	property p_load_high;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(LOAD_VALID_I && LOAD_PART_I == DSPDP_PART_HIGH) |=>
			gp_reg[$past(LOAD_REG_I)][31:16] == $past(LOAD_DATA_I[15:0]);
	endproperty
	a_load_high: assert property (p_load_high) else $error("high load wrong");

	property p_mac_psh16;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(OP_VALID_I && OP_CODE_I == DSPDP_OP_MAC_ADD && OP_PRESHIFT_I == DSPDP_PSH_BY16)
		|-> acc_in[39:24] == {16{gp_reg[OP_DST_I][39]}};
	endproperty
	a_mac_psh16: assert property (p_mac_psh16) else $error("preshift wrong");

	property p_mac;
		@(posedge CLK_SYS_I) disable iff (!RESETN_I)
		(OP_VALID_I && OP_CODE_I == DSPDP_OP_MAC_ADD && !LOAD_VALID_I)
		|=> RESULT_O == 40'($past(acc_in) + 40'($past(product)));
	endproperty
	a_mac: assert property (p_mac) else $error("mac sum wrong");

endmodule

// File: testbench/dspdp_mem_model.sv
// data memory store side model: captures every register store the datapath hands out
// assumes store data is qualified by a one cycle valid pulse on the system clock
module dspdp_mem_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// store path from the datapath
	input wire logic store_valid_i,
	input wire logic [39:0] store_data_i,
	// capture status
	output int stores_seen_o,
	output logic [39:0] last_word_o
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////////
	// memory writes one word per valid pulse, so a stuck valid shows as extra stores
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stores_seen_o <= 0;
			last_word_o <= 40'h00_0000_0000;
		end else if (store_valid_i) begin // a word leaves the register file
			stores_seen_o <= stores_seen_o + 1;
			last_word_o <= store_data_i;
		end
	end
endmodule

// File: testbench/tb.sv
// self-checking bench for the arithmetic datapath, random issue with corner shifts
// assumes one operation, load and store may all be issued in the same cycle
module tb;
	import dspdp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, op_valid, ma, mb, ld_valid, st_req;
	logic [3:0] op_code;
	logic [2:0] dst, sa, sb, ld_reg, st_reg;
	logic [1:0] psh, ld_part, st_part;
	logic [5:0] shamt;
	logic [39:0] ld_data, store_data, result;
	logic store_valid, done;
	logic [39:0] gp [0:7]; // reference register file
	logic [39:0] e_res, e_sd, n_res, n_sd;
	logic e_done, e_sv, n_done, n_sv;
	logic e_shift, n_shift; // result came from the barrel shifter
	logic [39:0] last_word, e_last; // last word the memory side captured
	int err_total, samples_checked, cyc, exp_stores, stores_seen, i;
	integer seed; // $random wants an integer seed variable
	////////////////////////////////////////////////////////////////////////////////
	// design and store side partner
	dspdp_top uut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .OP_VALID_I(op_valid),
		.OP_CODE_I(op_code), .OP_DST_I(dst), .OP_SRCA_I(sa), .OP_SRCB_I(sb),
		.OP_MUL_A_HIGH_I(ma), .OP_MUL_B_HIGH_I(mb), .OP_PRESHIFT_I(psh), .OP_SHAMT_I(shamt),
		.LOAD_VALID_I(ld_valid), .LOAD_REG_I(ld_reg), .LOAD_PART_I(ld_part),
		.LOAD_DATA_I(ld_data), .STORE_REQ_I(st_req), .STORE_REG_I(st_reg),
		.STORE_PART_I(st_part), .STORE_VALID_O(store_valid), .STORE_DATA_O(store_data),
		.DONE_O(done), .RESULT_O(result));
	dspdp_mem_model mem (.clk_i(clk), .resetn_i(rst_n), .store_valid_i(store_valid),
		.store_data_i(store_data), .stores_seen_o(stores_seen), .last_word_o(last_word));
	////////////////////////////////////////////////////////////////////////////////
	// reference functions
	function automatic logic [39:0] f_op(input logic [3:0] c, input logic [39:0] a, b, d,
		input logic xh, yh, input logic [1:0] p, input logic [5:0] s);
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [39:0] pr;
		logic signed [39:0] acc;
		x = xh ? a[31:16] : a[15:0];
		y = yh ? b[31:16] : b[15:0];
		pr = x * y;
		acc = d;
		if (p == 2'h1) acc = acc >>> 1; // pre-shift by one
		if (p == 2'h3) acc = acc >>> 16; // pre-shift by sixteen
		case (c)
			4'h1: return acc + pr;
			4'h2: return acc - pr;
			4'h3: return a + b;
			4'h4: return a - b;
			4'h5: return a & b;
			4'h6: return a | b;
			4'h7: return a ^ b;
			4'h8: return -a;
			4'h9: return ~a;
			4'hB: return (s >= 6'h28) ? 40'h00_0000_0000 : a << s;
			// both arms signed, or the unsigned fill would turn >>> into a logical shift
			4'hC: return (s >= 6'h28) ? $signed({40{a[39]}}) : $signed(a) >>> s;
			4'hD: return (s >= 6'h28) ? 40'h00_0000_0000 : a >> s;
			default: return a; // pass, and the spare codes behave as pass
		endcase
	endfunction
	function automatic logic [39:0] f_rd(input logic [39:0] v, input logic [1:0] p);
		case (p)
			2'h0: return {24'h00_0000, v[15:0]};
			2'h1: return {24'h00_0000, v[31:16]};
			2'h2: return {32'h0000_0000, v[39:32]};
			default: return v;
		endcase
	endfunction
	function automatic logic [39:0] f_wr(input logic [39:0] v, input logic [1:0] p,
		input logic [39:0] d);
		case (p)
			2'h0: return {v[39:16], d[15:0]};
			2'h1: return {v[39:32], d[15:0], v[15:0]};
			2'h2: return {d[7:0], v[31:0]};
			default: return d;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// compare tasks and closing report
	task automatic chk_bit(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_word(input string nm, input logic [39:0] e, input logic [39:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin // far above the 2004 cycles the run needs
			err_total++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// one cycle of issue: random fields, the first eight cycles read back reset state
	task automatic step(input int k);
		logic [31:0] r;
		r = $random(seed);
		op_valid <= (k >= 8) && r[0];
		op_code <= r[4:1];
		dst <= r[7:5];
		sa <= r[10:8];
		sb <= r[13:11];
		ma <= r[14];
		mb <= r[15];
		psh <= r[17:16];
		shamt <= r[18] ? r[24:19] : {3'h0, r[21:19]} * 6'h09; // 0,9..63 corners
		ld_valid <= (k >= 8) && r[25];
		ld_reg <= r[28:26];
		ld_part <= r[30:29];
		ld_data <= 40'({$random(seed), $random(seed)});
		st_req <= (k < 8) || r[31];
		st_reg <= (k < 8) ? k[2:0] : r[7:5];
		st_part <= (k < 8) ? 2'h3 : r[2:1];
		#1;
		n_sv = st_req;
		n_sd = f_rd(gp[st_reg], st_part); // read before any same-cycle write
		n_done = op_valid && (op_code != 4'h0);
		n_res = f_op(op_code, gp[sa], gp[sb], gp[dst], ma, mb, psh, shamt);
		n_shift = (op_code == 4'hB) || (op_code == 4'hC) || (op_code == 4'hD);
		if (n_done) gp[dst] = n_res;
		if (ld_valid) gp[ld_reg] = f_wr(gp[ld_reg], ld_part, ld_data); // load wins
		exp_stores += n_sv;
		if (n_sv) e_last = n_sd;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence: back to back issue, each result checked one edge later
	initial begin
		seed = 59;
		cyc = 0;
		err_total = 0;
		samples_checked = 0;
		exp_stores = 0;
		e_done = 1'b0;
		e_sv = 1'b0;
		e_res = 40'h00_0000_0000;
		e_sd = 40'h00_0000_0000;
		e_shift = 1'b0;
		e_last = 40'h00_0000_0000;
		for (i = 0; i < 8; i++) gp[i] = 40'h00_0000_0000;
		{op_valid, ld_valid, st_req, ma, mb} = 5'h00;
		{op_code, dst, sa, sb, psh, shamt} = 21'h00_0000;
		{ld_reg, ld_part, st_reg, st_part} = 10'h000;
		ld_data = 40'h00_0000_0000;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 2000; i++) begin
			@(posedge clk);
			step(i);
			chk_bit("done", e_done, done);
			if (e_done && e_shift) chk_word("shift", e_res, result);
			if (e_done && !e_shift) chk_word("result", e_res, result);
			chk_bit("store_valid", e_sv, store_valid);
			if (e_sv) chk_word("store_data", e_sd, store_data);
			{e_done, e_shift, e_res, e_sv, e_sd} = {n_done, n_shift, n_res, n_sv, n_sd};
		end
		@(posedge clk);
		{op_valid, ld_valid, st_req} <= 3'h0;
		#1;
		chk_bit("done", e_done, done);
		chk_bit("store_valid", e_sv, store_valid);
		@(posedge clk);
		#1;
		chk_word("stores", 40'(exp_stores), 40'(stores_seen));
		chk_word("last_word", e_last, last_word);
		end_sim();
	end
endmodule
